/* File: rtl/iwc_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes synchronous active-high reset on the shared clock.
module iwc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic ref_clk,
   input  wire logic srst,
   iwc_stream_if.snk wr,
   iwc_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wptr_q;
   logic [AW-1:0]    rptr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
   assign rd.valid = (cnt_q != '0);
   assign rd.data  = mem_q[rptr_q];
   assign push     = wr.valid & wr.ready;
   assign pop      = rd.valid & rd.ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wptr_q] <= wr.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : iwc_fifo

/* File: rtl/iwc_pkg.sv */
// Shared constants and types for the two-wire wait-state controller.
// Assumes a 100 MHz ref_clk and open-drain lines resolved outside the design.
package iwc_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          SCL_HALF_NS     = 2500;
   localparam int          SCL_HALF_CYC    = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W           = 12;
   // ************************************************************
   // Byte framing
   // ************************************************************
   localparam int          DATA_W          = 8;
   localparam logic [3:0]  SLAVE_WAIT_CLK  = 4'h8;
   localparam logic [3:0]  MASTER_WAIT_CLK = 4'h9;
   localparam logic [3:0]  BIT_RESET       = 4'h0;
   localparam logic [7:0]  RELEASE_BYTE    = 8'hff;
   localparam logic [7:0]  SHIFT_RESET     = 8'hff;
   localparam int          FIFO_DEPTH      = 4;

   typedef enum logic [2:0] {
      IWC_IDLE  = 3'b000,
      IWC_LOW   = 3'b001,
      IWC_HIGH  = 3'b011,
      IWC_WAIT  = 3'b010,
      IWC_HOLD  = 3'b110
   } iwc_state_t;
endpackage : iwc_pkg

/* File: rtl/iwc_stream_if.sv */
// Valid/ready word stream between the controller and its FIFO.
// Assumes one clock domain shared by both ends.
interface iwc_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : iwc_stream_if

/* File: rtl/iwc_wait_ctrl.sv */
// Wait-state controller for one two-wire bus port, master or slave role.
// Assumes open-drain lines resolved outside; both lines come from pins.
module iwc_wait_ctrl #(
   parameter int HALF_CYC = iwc_pkg::SCL_HALF_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic       master_mode,
   input  wire logic       ack_generation_enable,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_valid,
   output logic            wr_ready,
   input  wire logic       wait_release_bit,
   input  wire logic       serial_clock_line_i,
   output logic            serial_clock_line_o,
   output logic            serial_clock_line_oe,
   input  wire logic       serial_data_line_i,
   output logic            serial_data_line_o,
   output logic            serial_data_line_oe,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            in_wait
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic       scl_m_q, scl_s_q, scl_p_q;
   logic       sda_m_q, sda_s_q;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         scl_m_q <= serial_clock_line_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= serial_data_line_i;
         sda_s_q <= sda_m_q;
      end
   end
   logic scl_rise, scl_fall;
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;

   // ************************************************************
   // Transmit FIFO
   // ************************************************************
   iwc_stream_if #(.W(iwc_pkg::DATA_W)) s_in ();
   iwc_stream_if #(.W(iwc_pkg::DATA_W)) s_out ();
   assign s_in.data  = wr_data;
   assign s_in.valid = wr_valid;
   iwc_fifo #(.WIDTH(iwc_pkg::DATA_W), .DEPTH(iwc_pkg::FIFO_DEPTH)) u_fifo (
      .ref_clk (ref_clk),
      .srst    (srst),
      .wr      (s_in),
      .rd      (s_out)
   );
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_ready <= 1'b0;
      end else begin
         wr_ready <= s_in.ready;
      end
   end

   // ************************************************************
   // Byte engine
   // ************************************************************
   iwc_pkg::iwc_state_t state_q;
   logic [iwc_pkg::CNT_W-1:0] tmr_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;
   logic [7:0]  rxs_q;
   logic        cancel;
   logic        release_cmd;
   logic        tmr_done;
   logic        wait_clk_hit;
   logic [3:0]  wait_at;

   // Master that transmits waits after ACK; slave receiver before it with ACK generation on, after it with it off
   assign wait_at      = master_mode ? iwc_pkg::MASTER_WAIT_CLK :
                         (ack_generation_enable ? iwc_pkg::SLAVE_WAIT_CLK
                                                : iwc_pkg::MASTER_WAIT_CLK);
   assign tmr_done     = (tmr_q == '0);
   // Release byte only counts as a slave cancel in slave role
   assign release_cmd  = master_mode ? s_out.valid
                                     : ((s_out.valid && s_out.data == iwc_pkg::RELEASE_BYTE)
                                        || wait_release_bit);
   assign cancel       = (state_q == iwc_pkg::IWC_WAIT) && release_cmd;
   assign s_out.ready  = cancel && s_out.valid;
   assign wait_clk_hit = (bit_q == wait_at);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= iwc_pkg::IWC_WAIT;
         tmr_q   <= '0;
         bit_q   <= iwc_pkg::BIT_RESET;
      end else begin
         unique case (state_q)
            iwc_pkg::IWC_IDLE: begin
               state_q <= iwc_pkg::IWC_WAIT;
            end
            iwc_pkg::IWC_WAIT: begin
               if (cancel) begin
                  // A slave wait before the ACK clock resumes into that clock
                  bit_q   <= (bit_q < iwc_pkg::MASTER_WAIT_CLK) ? bit_q : iwc_pkg::BIT_RESET;
                  tmr_q   <= iwc_pkg::CNT_W'(HALF_CYC);
                  state_q <= iwc_pkg::IWC_HOLD;
               end
            end
            iwc_pkg::IWC_HOLD: begin
               // Master keeps the clock low a half period so new data settles first
               if (master_mode && !tmr_done) begin
                  tmr_q <= tmr_q - 1'b1;
               // Line must read high before any clock is made
               end else if (scl_s_q) begin
                  tmr_q   <= iwc_pkg::CNT_W'(HALF_CYC);
                  state_q <= master_mode ? iwc_pkg::IWC_HIGH : iwc_pkg::IWC_LOW;
               end
            end
            iwc_pkg::IWC_LOW: begin
               if (master_mode) begin
                  if (tmr_done) begin
                     tmr_q   <= iwc_pkg::CNT_W'(HALF_CYC);
                     state_q <= iwc_pkg::IWC_HIGH;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end else if (scl_rise) begin
                  state_q <= iwc_pkg::IWC_HIGH;
               end
            end
            iwc_pkg::IWC_HIGH: begin
               if (master_mode) begin
                  // Stretching by the far side reloads the timer to a full half period
                  if (!scl_s_q) begin
                     tmr_q <= iwc_pkg::CNT_W'(HALF_CYC);
                  end else if (tmr_done) begin
                     bit_q   <= bit_q + 1'b1;
                     tmr_q   <= iwc_pkg::CNT_W'(HALF_CYC);
                     state_q <= (bit_q + 1'b1 == wait_at) ? iwc_pkg::IWC_WAIT : iwc_pkg::IWC_LOW;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end else if (scl_fall) begin
                  if (bit_q + 1'b1 == wait_at) begin
                     bit_q   <= bit_q + 1'b1;
                     state_q <= iwc_pkg::IWC_WAIT;
                  end else if (bit_q + 1'b1 == iwc_pkg::MASTER_WAIT_CLK) begin
                     bit_q   <= iwc_pkg::BIT_RESET;
                     state_q <= iwc_pkg::IWC_LOW;
                  end else begin
                     bit_q   <= bit_q + 1'b1;
                     state_q <= iwc_pkg::IWC_LOW;
                  end
               end
            end
            default: begin
               state_q <= iwc_pkg::IWC_WAIT;
            end
         endcase
      end
   end

   // ************************************************************
   // Shift and receive data
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sh_q     <= iwc_pkg::SHIFT_RESET;
         rxs_q    <= '0;
         rx_data  <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (cancel) begin
            sh_q <= s_out.valid ? s_out.data : iwc_pkg::SHIFT_RESET;
         end else if (state_q == iwc_pkg::IWC_HIGH && bit_q < 4'h8 &&
                      ((master_mode && scl_s_q && tmr_done) || (!master_mode && scl_fall))) begin
            // Shift only after the high phase so data never moves under a high clock
            sh_q  <= {sh_q[6:0], 1'b1};
            rxs_q <= {rxs_q[6:0], sda_s_q};
            if (bit_q == 4'h7) begin
               rx_data  <= {rxs_q[6:0], sda_s_q};
               rx_valid <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // Pin drivers
   // ************************************************************
   logic drive_low_d;
   logic sda_low_d;
   always_comb begin
      drive_low_d = 1'b0;
      if (state_q == iwc_pkg::IWC_WAIT) begin
         drive_low_d = 1'b1;
      end else if (master_mode && state_q == iwc_pkg::IWC_LOW) begin
         drive_low_d = 1'b1;
      end else if (master_mode && state_q == iwc_pkg::IWC_HOLD && !tmr_done) begin
         drive_low_d = 1'b1;
      end
      sda_low_d = 1'b0;
      if (bit_q < 4'h8) begin
         sda_low_d = ~sh_q[7];
      end else if (bit_q == 4'h8 && !master_mode && ack_generation_enable) begin
         sda_low_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         serial_clock_line_o  <= 1'b0;
         serial_clock_line_oe <= 1'b1;
         serial_data_line_o   <= 1'b0;
         serial_data_line_oe  <= 1'b0;
         in_wait              <= 1'b1;
      end else begin
         serial_clock_line_o  <= 1'b0;
         serial_clock_line_oe <= drive_low_d;
         serial_data_line_o   <= 1'b0;
         // Data line only updates while the clock is held low
         if (!scl_s_q) begin
            serial_data_line_oe <= sda_low_d;
         end
         in_wait <= (state_q == iwc_pkg::IWC_WAIT);
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_wait_holds_low: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == iwc_pkg::IWC_WAIT) |=> serial_clock_line_oe)
      else $error("clock not held low during wait");
   a_hold_no_clock: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == iwc_pkg::IWC_HOLD && !scl_s_q) |=> (state_q == iwc_pkg::IWC_HOLD))
      else $error("left hold while line low");
   a_wait_point: assert property (@(posedge ref_clk) disable iff (srst)
      ($rose(state_q == iwc_pkg::IWC_WAIT) && !$past(srst)) |-> (bit_q == wait_at))
      else $error("wait entered at wrong clock");
   a_stretch_stall: assert property (@(posedge ref_clk) disable iff (srst)
      (master_mode && state_q == iwc_pkg::IWC_HIGH && !scl_s_q) |=> (tmr_q == iwc_pkg::CNT_W'(HALF_CYC)))
      else $error("master ran through stretch");
   a_master_cancel: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == iwc_pkg::IWC_WAIT && master_mode && s_out.valid) |=> (state_q == iwc_pkg::IWC_HOLD))
      else $error("master write did not cancel");
   a_slave_release: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == iwc_pkg::IWC_WAIT && !master_mode && wait_release_bit) |=> ##1 !serial_clock_line_oe)
      else $error("release bit did not free clock");
   a_slave_no_cancel: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == iwc_pkg::IWC_WAIT && !master_mode && !wait_release_bit && !s_out.valid)
      |=> (state_q == iwc_pkg::IWC_WAIT))
      else $error("slave wait left without cancel");
   a_resume_msb: assert property (@(posedge ref_clk) disable iff (srst)
      (cancel && bit_q == iwc_pkg::MASTER_WAIT_CLK) |=> (bit_q == iwc_pkg::BIT_RESET))
      else $error("resume not at top bit");
   c_master_cancel: cover property (@(posedge ref_clk) disable iff (srst) cancel && master_mode);
   c_slave_release: cover property (@(posedge ref_clk) disable iff (srst) cancel && !master_mode);
   c_byte_received: cover property (@(posedge ref_clk) disable iff (srst) rx_valid);
endmodule : iwc_wait_ctrl

/* File: test/iwc_partner.sv */
// Far-side bus device: master sender or clock-stretching slave receiver.
// Assumes the bench resolves both open-drain lines with pull-ups.
module iwc_partner (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       slave_en   = 1'b0;
   int         stretch_ns = 0;
   int         nb         = 0;
   logic [7:0] sh;
   logic [7:0] got_q[$];
   initial scl_low = 1'b0;
   initial sda_low = 1'b0;
   // Data let go before the clock, so no edge on data while clock high
   task automatic idle();
      sda_low = 1'b0;
      #20;
      scl_low = 1'b0;
      nb = 0;
   endtask
   task automatic wait_high();
      for (int n = 0; n < 3000 && scl !== 1'b1; n++) #10;
   endtask
   // ************************************************************
   // Master role, 125 ns clock, MSB first
   // ************************************************************
   task automatic send_byte(input logic [7:0] d, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         scl_low = 1'b1;
         #31;
         sda_low = (i > 0) ? !d[i-1] : 1'b0;
         #31.5;
         scl_low = 1'b0;
         wait_high();
         ack = sda;
         #62.5;
      end
      // Clock stands still, held low, between bytes
      scl_low = 1'b1;
   endtask
   // ************************************************************
   // Slave role: stretches the clock before acknowledging
   // ************************************************************
   always @(posedge scl) begin
      if (slave_en && nb < 8) begin
         sh = {sh[6:0], sda};
         nb++;
         if (nb == 8) got_q.push_back(sh);
      end
   end
   always @(negedge scl) begin
      if (slave_en && nb == 8) begin
         sda_low = 1'b1;
         scl_low = 1'b1;
         #(stretch_ns);
         scl_low = 1'b0;
         nb = 9;
      end else if (slave_en && nb == 9) begin
         #20;
         sda_low = 1'b0;
         nb = 0;
      end
   end
endmodule // iwc_partner

/* File: test/tb_top.sv */
// Self-checking bench for the wait-state controller, slave and master roles.
// Assumes the partner model on the far side and pull-ups on both lines.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 6;
   logic       ref_clk;
   logic       srst             = 1'b1;
   logic       master_mode      = 1'b0;
   logic       wr_valid         = 1'b0;
   logic       wait_release_bit = 1'b0;
   logic [7:0] wr_data          = 8'h00;
   logic       wr_ready, scl_o, scl_oe, sda_o, sda_oe, rx_valid, in_wait, p_scl, p_sda, ok, ack;
   logic [7:0] rx_data, rx_last, rises, d;
   logic [7:0] exp_q[$];
   int         seed       = 1;
   int         bad_count  = 0;
   int         n_compared = 0;
   wire        scl = !((scl_oe && !scl_o) || p_scl);
   wire        sda = !((sda_oe && !sda_o) || p_sda);
   iwc_wait_ctrl #(.HALF_CYC(HALF)) u_iwc_wait_ctrl (
      .ref_clk(ref_clk), .srst(srst), .master_mode(master_mode), .ack_generation_enable(1'b1),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wait_release_bit(wait_release_bit),
      .serial_clock_line_i(scl), .serial_clock_line_o(scl_o), .serial_clock_line_oe(scl_oe),
      .serial_data_line_i(sda), .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe),
      .rx_data(rx_data), .rx_valid(rx_valid), .in_wait(in_wait));
   iwc_partner u_iwc_partner (.scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk) if (rx_valid === 1'b1) rx_last <= rx_data;
   always @(posedge scl) rises = rises + 8'h01;
   always @(sda) if (scl === 1'b1 && srst === 1'b0) check("data steady", 8'h00, 8'h01);
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Request held until the edge that samples ready high
   task automatic wr_byte(input logic [7:0] v, output logic acc);
      @(negedge ref_clk);
      wr_data = v;
      wr_valid = 1'b1;
      acc = 1'b0;
      // Ready read at the falling edge is the FIFO ready registered at the rising edge before, one cycle behind the FIFO
      for (int n = 0; n < 20 && !acc; n++) begin
         acc = (wr_ready === 1'b1);
         @(posedge ref_clk);
      end
      @(negedge ref_clk);
      wr_valid = 1'b0;
   endtask
   task automatic wait_lvl(input logic lvl);
      for (int n = 0; n < 3000 && in_wait !== lvl; n++) @(negedge ref_clk);
      check("wait level", {7'h00, in_wait}, {7'h00, lvl});
   endtask
   task automatic do_reset(input logic mm);
      @(negedge ref_clk);
      srst = 1'b1;
      master_mode = mm;
      repeat (12) @(negedge ref_clk);
      srst = 1'b0;
      repeat (3) @(negedge ref_clk);
      check("wait after reset", {7'h00, in_wait}, 8'h01);
      check("clock held after reset", {7'h00, scl}, 8'h00);
      u_iwc_partner.idle();
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      // Slave: all-ones write cancels, far master stalls on the wait
      do_reset(1'b0);
      wr_byte(8'hff, ok);
      wait_lvl(1'b0);
      repeat (5) @(negedge ref_clk);
      rises = 8'h00;
      rx_last = 8'hxx;
      d = 8'($random(seed));
      fork
         u_iwc_partner.send_byte(d, ack);
         begin
            wait_lvl(1'b1);
            check("clocks before slave wait", rises, 8'h08);
            repeat (30) begin
               @(negedge ref_clk);
               check("clock held in wait", {7'h00, scl}, 8'h00);
            end
            wait_release_bit = 1'b1;
            wait_lvl(1'b0);
            @(negedge ref_clk);
            wait_release_bit = 1'b0;
         end
      join
      check("ack from slave", {7'h00, ack}, 8'h00);
      check("received byte", rx_last, d);
      // Slave: a non-ff head never cancels; FIFO fills and refuses
      do_reset(1'b0);
      for (int i = 0; i < 5; i++) begin
         wr_byte(8'($random(seed)) & 8'h7f, ok);
         check("fifo accepts", {7'h00, ok}, {7'h00, (i < 4)});
      end
      check("non-ff keeps wait", {7'h00, in_wait}, 8'h01);
      // Master: release bit ignored, writes cancel, far slave stretches
      do_reset(1'b1);
      u_iwc_partner.slave_en = 1'b1;
      u_iwc_partner.stretch_ns = 800;
      rises = 8'h00;
      wait_release_bit = 1'b1;
      repeat (30) @(negedge ref_clk);
      check("master ignores release bit", {7'h00, in_wait}, 8'h01);
      wait_release_bit = 1'b0;
      for (int i = 0; i < 2; i++) begin
         d = 8'($random(seed));
         exp_q.push_back(d);
         wr_byte(d, ok);
      end
      for (int n = 0; n < 3000 && !(u_iwc_partner.got_q.size() == 2 && in_wait === 1'b1); n++) @(negedge ref_clk);
      repeat (40) @(negedge ref_clk);
      check("clocks for two bytes", rises, 8'h12);
      check("bytes at far side", 8'(u_iwc_partner.got_q.size()), 8'h02);
      while (exp_q.size() > 0 && u_iwc_partner.got_q.size() > 0)
         check("far side byte", u_iwc_partner.got_q.pop_front(), exp_q.pop_front());
      end_of_test();
   end
   initial begin
      #500000;
      bad_count++;
      end_of_test();
   end
endmodule // tb_top
